// [inc/spicmd_pkg.sv]
// Constants, codes and carrier types for the serial EEPROM command engine
// Functional notes
// - Capture on falling clock, drive after rising.
// - Deselect tristates output; standby unless writing.
// - Lock low refuses writes, clears latch.
// - Started write cycle is never aborted.
// - Pause only while selected, clock low edges.
// - Deselect while paused: stays paused, serial reset.
// - Works in clock modes (0,1) and (1,0).
// - All bytes shifted most significant bit first.
// - First eight bits after select are instruction.
// - Unknown instruction deselects until next selection.
// - Decode latch set, latch clear, status read.
// - Decode status write, array read, array write.
// - Instruction bit 3 is address bit 8; bit 9 zero.
// - Latch clears on lock, reset, clear, writes.
// - Latch commands act at once, then wait.
// - Status readable anytime; after 8 bits wait.
// - Status byte: ones, protect bits, latch, busy.
// - Status write shows old protect bits.
// - Protect bits block array ranges from writes.
// - Status write starts only on exact select rise.
// - Array read streams, address increments and wraps.
// - Page write 1..16 bytes, wraps, exact rise.
// - Array access during write deselects, write continues.
package spicmd_pkg;

  localparam int SPICMD_ADDR_W = 10;
  localparam int SPICMD_PAGE_W = 4;
  localparam int SPICMD_DEPTH = 1024;
  localparam int SPICMD_CLK_MHZ = 200;
  // Write cycle time in microseconds and its cycle count
  localparam int SPICMD_WRITE_US = 10000;
  localparam int SPICMD_WRITE_CYC = SPICMD_WRITE_US * SPICMD_CLK_MHZ;
  // Status byte layout
  localparam logic [3:0] SPICMD_STAT_ONES = 4'hF;
  localparam int SPICMD_BIT_BUSY = 0;
  localparam int SPICMD_BIT_LATCH = 1;
  localparam logic [1:0] SPICMD_PROT_RESET = 2'h0;
  localparam logic [7:0] SPICMD_ERASED = 8'hFF;
  // Opcode low bits; bits 7:5 must be zero, bits 4:3 ignored
  localparam logic [2:0] SPICMD_OP_LSET = 3'h6;
  localparam logic [2:0] SPICMD_OP_LCLR = 3'h4;
  localparam logic [2:0] SPICMD_OP_SRD = 3'h5;
  localparam logic [2:0] SPICMD_OP_SWR = 3'h1;
  localparam logic [2:0] SPICMD_OP_ARD = 3'h3;
  localparam logic [2:0] SPICMD_OP_AWR = 3'h2;
  localparam int SPICMD_OP_ABIT = 3;
  // Protected ranges start
  localparam logic [SPICMD_ADDR_W-1:0] SPICMD_PROT_QUART = 10'h300;
  localparam logic [SPICMD_ADDR_W-1:0] SPICMD_PROT_HALF = 10'h200;
  localparam logic [SPICMD_ADDR_W-1:0] SPICMD_PROT_ALL = 10'h000;

  typedef enum logic [7:0] {
    SPICMD_ST_OP = 8'h01,
    SPICMD_ST_ADDR = 8'h02,
    SPICMD_ST_RDATA = 8'h04,
    SPICMD_ST_WDATA = 8'h08,
    SPICMD_ST_SRD = 8'h10,
    SPICMD_ST_SWR = 8'h20,
    SPICMD_ST_WAIT = 8'h40,
    SPICMD_ST_IDLE = 8'h80
  } spicmd_state_t;

  // Synchronised link pins
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic din;
    logic pause_n;
    logic lock_n;
  } spicmd_pins_t;

endpackage

// [design/spicmd_engine.sv]
// Serial command engine of an SPI EEPROM with status and write protection
`timescale 1ns/1ps
`default_nettype none
module spicmd_engine
  import spicmd_pkg::*;
#(
  parameter int WRITE_CYC = SPICMD_WRITE_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic unit_enable_n,
  input wire logic shift_timing,
  input wire logic serial_input,
  input wire logic pause_input,
  input wire logic program_lock_n,
  output logic serial_output,
  output logic serial_output_oe_n,
  output logic busy_flag,
  output logic write_latch_flag
);

  // Three-stage synchronisers; a change counts when stages two and three agree.
  // The agreement test also rejects single-sample glitches shorter than a cycle,
  // at the cost of one more cycle of latency on every pin.
  spicmd_pins_t raw, s1_q, s2_q, s3_q, fil_q;
  assign raw = '{sel_n: unit_enable_n, sck: shift_timing, din: serial_input,
                 pause_n: pause_input, lock_n: program_lock_n};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '{sel_n: 1'b1, sck: 1'b0, din: 1'b0, pause_n: 1'b1, lock_n: 1'b1};
      s2_q <= '{sel_n: 1'b1, sck: 1'b0, din: 1'b0, pause_n: 1'b1, lock_n: 1'b1};
      s3_q <= '{sel_n: 1'b1, sck: 1'b0, din: 1'b0, pause_n: 1'b1, lock_n: 1'b1};
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered view per pin; hold last value while stages disagree
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_fil
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          fil_q[gi] <= (gi == 4 || gi == 1 || gi == 0) ? 1'b1 : 1'b0;
        end else if (s2_q[gi] == s3_q[gi]) begin
          fil_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  spicmd_pins_t nxt;
  assign nxt = (s2_q == s3_q) ? s3_q : fil_q;
  // Edges seen on the filtered pins, one cycle before the view updates.
  // Data and clock share one pipeline, so a bit taken on a clock fall
  // sees the data level that stood at that fall.
  logic sck_fall, sck_rise, sel_fall, sel_rise, pause_fall, pause_rise, lock_fall;
  assign sck_fall = fil_q.sck & ~nxt.sck;
  assign sck_rise = ~fil_q.sck & nxt.sck;
  assign sel_fall = fil_q.sel_n & ~nxt.sel_n;
  assign sel_rise = ~fil_q.sel_n & nxt.sel_n;
  assign pause_fall = fil_q.pause_n & ~nxt.pause_n;
  assign pause_rise = ~fil_q.pause_n & nxt.pause_n;
  assign lock_fall = fil_q.lock_n & ~nxt.lock_n;

  // Array storage; contents are undefined until first programmed, since
  // the erased delivery state is not modelled and a reset must not wipe it
  logic [7:0] mem_q [SPICMD_DEPTH];
  logic [7:0] page_q [1 << SPICMD_PAGE_W];
  logic [(1 << SPICMD_PAGE_W)-1:0] page_vld_q;

  spicmd_state_t st_q;
  logic paused_q, armed_q;
  logic [7:0] sh_q;
  logic [2:0] bcnt_q;
  logic [SPICMD_ADDR_W-1:0] addr_q;
  logic [1:0] prot_q, prot_new_q;
  logic latch_q;
  logic [7:0] obyte_q;
  logic drive_q;
  logic done_q; // Exactly a byte boundary with nothing after it
  logic go_arr_q, go_stat_q;
  logic [31:0] wcnt_q;
  logic busy_q, wr_is_stat_q;
  logic [SPICMD_ADDR_W-1:0] wbase_q;

  // Clock mode is irrelevant: only falling/rising edges while selected matter
  logic active;
  assign active = ~fil_q.sel_n & ~paused_q;

  // Decoded opcode from the byte about to complete
  // Bits 4:3 are ignored here; bit 3 is reused as address bit 8, and bit 9 is cleared
  logic [7:0] opb;
  logic op_ok;
  assign opb = {sh_q[6:0], nxt.din};
  assign op_ok = (opb[7:5] == 3'h0) &&
                 (opb[2:0] == SPICMD_OP_LSET || opb[2:0] == SPICMD_OP_LCLR ||
                  opb[2:0] == SPICMD_OP_SRD || opb[2:0] == SPICMD_OP_SWR ||
                  opb[2:0] == SPICMD_OP_ARD || opb[2:0] == SPICMD_OP_AWR);

  // Protection check for an array address
  // Reads are never checked: protection only gates programming
  function automatic logic prot_hit(input logic [1:0] p, input logic [SPICMD_ADDR_W-1:0] a);
    unique case (p)
      2'h1: prot_hit = a >= SPICMD_PROT_QUART;
      2'h2: prot_hit = a >= SPICMD_PROT_HALF;
      2'h3: prot_hit = a >= SPICMD_PROT_ALL;
      default: prot_hit = 1'b0;
    endcase
  endfunction

  // Pause control: only while selected, edges taken while clock is low
  // A pause edge with the clock high is ignored, so the master must park the clock low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      paused_q <= 1'b0;
    end else if (!fil_q.sel_n && !fil_q.sck && pause_fall) begin
      paused_q <= 1'b1;
    end else if (!fil_q.sel_n && !fil_q.sck && pause_rise) begin
      paused_q <= 1'b0;
    end
  end
  // A deselect while paused leaves the pause standing

  // Serial sequencer; select fall restarts at the opcode
  // Deselect always wins; it is also the serial reset after a paused deselect
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= SPICMD_ST_IDLE;
      sh_q <= 8'h00;
      bcnt_q <= 3'h0;
      addr_q <= '0;
      armed_q <= 1'b0;
      done_q <= 1'b0;
    end else if (fil_q.sel_n) begin
      st_q <= SPICMD_ST_IDLE;
      bcnt_q <= 3'h0;
      done_q <= 1'b0;
      if (sel_fall) begin
        st_q <= SPICMD_ST_OP;
        armed_q <= 1'b0;
      end
    end else if (active && sck_fall) begin
      sh_q <= opb;
      bcnt_q <= bcnt_q + 3'h1;
      done_q <= (bcnt_q == 3'h7);
      if (bcnt_q == 3'h7) begin
        unique case (st_q)
          SPICMD_ST_OP: begin
            armed_q <= opb[2:0] == SPICMD_OP_AWR;
            addr_q[SPICMD_ADDR_W-1:8] <= {1'b0, opb[SPICMD_OP_ABIT]};
            if (!op_ok) begin
              st_q <= SPICMD_ST_IDLE;
            end else if ((opb[2:0] == SPICMD_OP_ARD || opb[2:0] == SPICMD_OP_AWR) && busy_q) begin
              st_q <= SPICMD_ST_IDLE;
            end else if (opb[2:0] == SPICMD_OP_ARD || opb[2:0] == SPICMD_OP_AWR) begin
              st_q <= SPICMD_ST_ADDR;
            end else if (opb[2:0] == SPICMD_OP_SRD) begin
              st_q <= SPICMD_ST_SRD;
            end else if (opb[2:0] == SPICMD_OP_SWR) begin
              st_q <= SPICMD_ST_SWR;
            end else begin
              st_q <= SPICMD_ST_WAIT;
            end
          end
          SPICMD_ST_ADDR: begin
            addr_q[7:0] <= opb;
            st_q <= armed_q ? SPICMD_ST_WDATA : SPICMD_ST_RDATA;
          end
          SPICMD_ST_RDATA: addr_q <= addr_q + 1'b1;
          SPICMD_ST_WDATA: addr_q[SPICMD_PAGE_W-1:0] <= addr_q[SPICMD_PAGE_W-1:0] + 1'b1;
          SPICMD_ST_SRD: st_q <= SPICMD_ST_WAIT;
          SPICMD_ST_SWR: st_q <= SPICMD_ST_WAIT;
          SPICMD_ST_WAIT, SPICMD_ST_IDLE: st_q <= st_q;
        endcase
      end
    end
  end

  // Page buffer collects bytes to program; wraps in the page
  // Flags clear at the next selection made outside a write cycle, not at deselect: the write start
  // comes a cycle after the select rise and must still see them.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_vld_q <= '0;
    end else if (sel_fall && !busy_q) begin
      page_vld_q <= '0;
    end else if (active && sck_fall && bcnt_q == 3'h7 && st_q == SPICMD_ST_WDATA) begin
      page_vld_q[addr_q[SPICMD_PAGE_W-1:0]] <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (active && sck_fall && bcnt_q == 3'h7 && st_q == SPICMD_ST_WDATA) begin
      page_q[addr_q[SPICMD_PAGE_W-1:0]] <= opb;
    end
  end

  // Marks that the wait state came from a completed status write byte
  logic swr_seen_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      swr_seen_q <= 1'b0;
    end else if (sel_fall) begin
      swr_seen_q <= 1'b0;
    end else if (active && sck_fall) begin
      swr_seen_q <= bcnt_q == 3'h7 && st_q == SPICMD_ST_SWR; // A 17th pulse drops it
    end
  end

  // Start conditions: select must rise just after a full byte
  // An array write also needs at least one data byte behind the address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      go_arr_q <= 1'b0;
      go_stat_q <= 1'b0;
    end else begin
      go_arr_q <= sel_rise && done_q && st_q == SPICMD_ST_WDATA && (|page_vld_q) &&
                  latch_q && fil_q.lock_n;
      go_stat_q <= sel_rise && done_q && st_q == SPICMD_ST_WAIT && !armed_q && swr_seen_q &&
                   latch_q && fil_q.lock_n;
    end
  end

  // New protect bits wait here until the status write cycle ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prot_new_q <= SPICMD_PROT_RESET;
    end else if (active && sck_fall && bcnt_q == 3'h7 && st_q == SPICMD_ST_SWR) begin
      prot_new_q <= opb[3:2];
    end
  end

  // Page base is taken only when an array write frame closes, so a status
  // read during the write cycle cannot move the page being programmed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wbase_q <= '0;
    end else if (sel_rise && st_q == SPICMD_ST_WDATA && !busy_q) begin
      wbase_q <= addr_q;
    end
  end

  // Self-timed write cycle; nothing aborts it once started
  // Counted in system clocks, so the write time follows the clock rate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      wcnt_q <= '0;
      wr_is_stat_q <= 1'b0;
      prot_q <= SPICMD_PROT_RESET;
    end else if (!busy_q && (go_arr_q || go_stat_q)) begin
      busy_q <= 1'b1;
      wcnt_q <= 32'(WRITE_CYC) - 32'h1;
      wr_is_stat_q <= go_stat_q;
    end else if (busy_q) begin
      if (wcnt_q == 32'h0) begin
        busy_q <= 1'b0;
        if (wr_is_stat_q) begin
          prot_q <= prot_new_q;
        end
      end else begin
        wcnt_q <= wcnt_q - 32'h1;
      end
    end
  end

  // Array programming on completion, protected bytes skipped
  always_ff @(posedge clk) begin
    if (busy_q && wcnt_q == 32'h0 && !wr_is_stat_q) begin
      for (int i = 0; i < (1 << SPICMD_PAGE_W); i++) begin
        if (page_vld_q[i] && !prot_hit(prot_q, {wbase_q[SPICMD_ADDR_W-1:SPICMD_PAGE_W], 4'(i)})) begin
          mem_q[{wbase_q[SPICMD_ADDR_W-1:SPICMD_PAGE_W], 4'(i)}] <= page_q[i];
        end
      end
    end
  end

  // Write enable latch: set wins only with lock high
  // Lock has priority: a set arriving in the cycle of a lock fall is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= 1'b0;
    end else if (!fil_q.lock_n || lock_fall) begin
      latch_q <= 1'b0;
    end else if (go_arr_q || go_stat_q) begin
      latch_q <= 1'b0;
    end else if (active && sck_fall && bcnt_q == 3'h7 && st_q == SPICMD_ST_OP && op_ok) begin
      if (opb[2:0] == SPICMD_OP_LSET) begin
        latch_q <= 1'b1;
      end else if (opb[2:0] == SPICMD_OP_LCLR) begin
        latch_q <= 1'b0;
      end
    end
  end

  // Output byte loaded at each boundary; status composed live
  // The status byte releases the line at its last clock fall, clocked on or not
  logic [7:0] stat_byte;
  assign stat_byte = {SPICMD_STAT_ONES, prot_q, latch_q, busy_q};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      obyte_q <= SPICMD_ERASED;
      drive_q <= 1'b0;
    end else if (fil_q.sel_n) begin
      drive_q <= 1'b0;
    end else if (active && sck_fall && bcnt_q == 3'h7 && st_q == SPICMD_ST_SRD) begin
      drive_q <= 1'b0;
    end else if (active && sck_rise) begin
      // Shift after the rising edge only
      if (bcnt_q == 3'h0 && st_q == SPICMD_ST_SRD) begin
        obyte_q <= stat_byte;
        drive_q <= 1'b1;
      end else if (bcnt_q == 3'h0 && st_q == SPICMD_ST_RDATA) begin
        obyte_q <= mem_q[addr_q];
        drive_q <= 1'b1;
      end else if (st_q == SPICMD_ST_SRD || st_q == SPICMD_ST_RDATA) begin
        obyte_q <= {obyte_q[6:0], 1'b1};
      end else begin
        drive_q <= 1'b0;
      end
    end
  end

  // Output pins registered; tristate while paused or deselected
  // Pins leave flops directly so no decode glitch reaches the bus
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_output <= 1'b1;
      serial_output_oe_n <= 1'b1;
      busy_flag <= 1'b0;
      write_latch_flag <= 1'b0;
    end else begin
      serial_output <= obyte_q[7];
      serial_output_oe_n <= ~(drive_q & active);
      busy_flag <= busy_q;
      write_latch_flag <= latch_q;
    end
  end

endmodule
`default_nettype wire

// [sim/spicmd_engine_assertions.sv]
// Port-level checker for the command engine
`timescale 1ns/1ps
`default_nettype none
module spicmd_engine_assertions #(
  parameter int WRITE_CYC = 50
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic unit_enable_n,
  input wire logic shift_timing,
  input wire logic serial_input,
  input wire logic pause_input,
  input wire logic program_lock_n,
  input wire logic serial_output,
  input wire logic serial_output_oe_n,
  input wire logic busy_flag,
  input wire logic write_latch_flag
);
  int unsigned busy_cnt_q;
  // Busy run length; a tolerance of one covers the edge that registers the flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_flag ? busy_cnt_q + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence clk_low_run;
    (!shift_timing) [*8];
  endsequence
  sequence out_held;
    !shift_timing && !serial_output_oe_n && !$past(serial_output_oe_n);
  endsequence
  deselect_hiz_a: assert property (unit_enable_n [*8] |-> serial_output_oe_n)
    else $error("output driven while deselected");
  out_timing_a: assert property (clk_low_run ##1 out_held |-> $stable(serial_output))
    else $error("output changed while clock low");
  pause_hiz_a: assert property (!pause_input [*8] |-> serial_output_oe_n)
    else $error("output driven while paused");
  lock_clear_a: assert property (!program_lock_n [*8] |-> !write_latch_flag)
    else $error("latch set while locked");
  lock_set_a: assert property ($rose(write_latch_flag) |-> program_lock_n)
    else $error("latch rose under lock");
  busy_start_a: assert property ($rose(busy_flag) |-> unit_enable_n)
    else $error("write began while selected");
  busy_latch_a: assert property ($rose(busy_flag) |-> ##[0:2] !write_latch_flag)
    else $error("latch kept after write start");
  busy_len_a: assert property ($fell(busy_flag) |-> busy_cnt_q + 1 >= WRITE_CYC && busy_cnt_q <= WRITE_CYC + 1)
    else $error("write cycle length wrong");
  busy_end_a: assert property ($fell(busy_flag) |-> !write_latch_flag)
    else $error("latch set at write end");
endmodule
bind spicmd_engine spicmd_engine_assertions #(.WRITE_CYC(WRITE_CYC)) i_chk (.clk(clk), .rst_b(rst_b),
  .unit_enable_n(unit_enable_n), .shift_timing(shift_timing), .serial_input(serial_input),
  .pause_input(pause_input), .program_lock_n(program_lock_n), .serial_output(serial_output),
  .serial_output_oe_n(serial_output_oe_n), .busy_flag(busy_flag), .write_latch_flag(write_latch_flag));
`default_nettype wire

// [sim/spicmd_master.sv]
// SPI master model on the far side of the engine
`timescale 1ns/1ps
`default_nettype none
module spicmd_master (
  input wire logic clk,
  input wire logic miso,
  input wire logic miso_oe_n,
  output var logic sel_n,
  output var logic sck,
  output var logic mosi,
  output var logic pause_n
);
  logic idle_hi = 1'b0; // Clock level between frames
  // Idle pins at time zero
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    pause_n = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Shift n bits from bit 31 down; 12 high plus 13 low clocks give 125 ns
  task automatic xfer(input logic [31:0] tx, input int n, input bit keep, output logic [31:0] rx, output logic drv);
    rx = '0;
    drv = 1'b0;
    if (sel_n) begin
      sck = idle_hi;
      wt(4);
      sel_n = 1'b0;
      wt(25);
    end
    for (int i = 0; i < n; i++) begin
      sck = 1'b1;
      mosi = tx[31-i];
      wt(12);
      rx = {rx[30:0], miso_oe_n ? ~miso : miso}; // An undriven line reads as the inverse
      drv = drv | ~miso_oe_n;
      sck = 1'b0;
      wt(13);
    end
    sck = idle_hi;
    if (!keep) begin
      wt(12);
      sel_n = 1'b1;
      mosi = ~mosi; // Released line must not keep its last value
      wt(40);
    end
  endtask
  // Pause with the clock low, report the output enable meanwhile
  task automatic hold(input int n, output logic hiz);
    pause_n = 1'b0;
    wt(n);
    hiz = miso_oe_n;
    pause_n = 1'b1;
    wt(12);
  endtask
endmodule
`default_nettype wire

// [sim/tb_spicmd_engine.sv]
// Self-checking bench for the command engine
`timescale 1ns/1ps
`default_nettype none
module tb_spicmd_engine;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic lock_n = 1'b1;
  wire logic sel_n, sck, mosi, pause_n, so, so_oe_n, busy, latch;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] rx;
  logic drv;
  initial begin
    forever #2.5 clk = ~clk;
  end
  spicmd_engine #(.WRITE_CYC(600)) i_dut (.clk(clk), .rst_b(rst_b), .unit_enable_n(sel_n), .shift_timing(sck),
    .serial_input(mosi), .pause_input(pause_n), .program_lock_n(lock_n), .serial_output(so),
    .serial_output_oe_n(so_oe_n), .busy_flag(busy), .write_latch_flag(latch));
  spicmd_master i_master (.clk(clk), .miso(so), .miso_oe_n(so_oe_n), .sel_n(sel_n), .sck(sck), .mosi(mosi),
    .pause_n(pause_n));
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic send(input logic [31:0] tx, input int n);
    i_master.xfer(tx, n, 1'b0, rx, drv);
  endtask
  task automatic status(input logic [7:0] exp);
    send(32'h0500_0000, 16);
    chk8("status", exp, rx[7:0]);
  endtask
  // Bounded wait for the write cycle to end
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    #1;
    if (k >= 1000) begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic t_latch();
    send(32'h1E05_0000, 16);
    chk1("drive after set", 1'b0, drv);
    status(8'hF2);
    send(32'h0C00_0000, 8);
    status(8'hF0);
  endtask
  task automatic t_bad();
    send(32'hFF05_0000, 16);
    chk1("drive after bad code", 1'b0, drv);
    i_master.idle_hi = 1'b1;
    status(8'hF0);
    i_master.idle_hi = 1'b0;
  endtask
  // Pause in mid status byte, while the output is being driven
  task automatic t_pause();
    logic [3:0] hi;
    i_master.xfer(32'h0500_0000, 12, 1'b1, rx, drv);
    hi = rx[3:0];
    i_master.hold(20, drv);
    chk1("hiz in pause", 1'b1, drv);
    send(32'h0, 4);
    chk8("status after pause", 8'hF0, {hi, rx[3:0]});
  endtask
  task automatic t_array();
    send(32'h0600_0000, 8);
    send(32'h0A0F_A53C, 32);
    chk1("busy", 1'b1, busy);
    send(32'h0B0F_0000, 24);
    chk1("drive while busy", 1'b0, drv);
    wait_idle();
    send(32'h0B0F_0000, 24);
    chk8("read 10F", 8'hA5, rx[7:0]);
    send(32'h0B00_0000, 24);
    chk8("read 100", 8'h3C, rx[7:0]);
  endtask
  task automatic t_lock();
    send(32'h0600_0000, 8);
    lock_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk1("latch under lock", 1'b0, latch);
    send(32'h0600_0000, 8);
    status(8'hF0);
    lock_n = 1'b1;
  endtask
  task automatic t_stat_write();
    send(32'h0600_0000, 8);
    send(32'h010C_0000, 16);
    status(8'hF1);
    wait_idle();
    status(8'hFC);
    send(32'h0600_0000, 8);
    send(32'h0100_0000, 17);
    chk1("busy after 17 clocks", 1'b0, busy);
    send(32'h0500_0000, 16);
    chk8("protect kept", 8'hFC, rx[7:0] & 8'hFD);
  endtask
  // Reset, then the scenarios in order
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk1("idle oe_n", 1'b1, so_oe_n);
    status(8'hF0);
    t_latch();
    t_bad();
    t_pause();
    t_array();
    t_lock();
    t_stat_write();
    complete_run();
  end
endmodule
`default_nettype wire
